// [hdl/amr_pkg.sv]
// Purpose: shared constants and types of the asynchronous read timing block
// Assumes: 16-bit control registers, CPU clock drives every register
// Notes: field positions follow the first control register layout

package amr_pkg;

  // ==========================================================================
  // register layout
  localparam int REG_W = 16;
  localparam int RSV_BIT = 15;        // reserved, always reads zero
  localparam int TYPE_LSB = 12;       // memory_kind_select
  localparam int TYPE_W = 3;
  localparam int SETUP_LSB = 8;       // read_setup_count
  localparam int SETUP_W = 4;
  localparam int STROBE_LSB = 2;      // read_strobe_count
  localparam int STROBE_W = 6;
  localparam int HOLD_LSB = 0;        // read_hold_count
  localparam int HOLD_W = 2;

  // register index inside one chip-enable space
  localparam logic [1:0] IDX_TIMING = 2'h0;
  localparam logic [1:0] IDX_CTL2 = 2'h1;
  localparam logic [1:0] IDX_CTL3 = 2'h2;

  // reset values
  localparam logic [15:0] CTL1_RST = 16'h2fff;
  localparam logic [15:0] CTL2_RST = 16'h0000;
  localparam logic [15:0] CTL3_RST = 16'h0000;
  localparam logic [15:0] CTL1_MASK = 16'h7fff;  // bit 15 never stored
  localparam logic [15:0] CTL3_MASK = 16'h00ff;  // upper byte reads zero

  // ==========================================================================
  // memory kind codes
  localparam logic [2:0] MT_ASYNC8 = 3'h0;
  localparam logic [2:0] MT_ASYNC16 = 3'h1;
  localparam logic [2:0] MT_ASYNC32 = 3'h2;
  localparam logic [2:0] MT_SDRAM = 3'h3;
  localparam logic [2:0] MT_BURST = 3'h4;

  // ==========================================================================
  // timing counts in cpu clock cycles
  localparam logic [3:0] SETUP_MIN_CODE = 4'h3;   // below this: one cycle, FIRST_SETUP on a first access
  localparam logic [5:0] FIRST_SETUP = 6'h02;     // least first setup
  localparam logic [5:0] ONE_CYCLE = 6'h01;
  localparam logic [5:0] STROBE_MIN_CODE = 6'h02; // below this: one cycle

  // ==========================================================================
  // access sequencer states, gray along idle-setup-strobe-hold
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2
  } amr_state_type;

endpackage : amr_pkg

// [hdl/amr_read_ctrl.sv]
// Purpose: per-space memory kind select and asynchronous read sequencer
// Assumes: clk is the cpu clock; ready and read data come from pins
// Notes: writes and synchronous kinds are handed off or refused here

`timescale 1ns/1ps

module amr_read_ctrl
  import amr_pkg::*;
#(
  parameter int N_SPACE = 4,
  parameter int SPACE_W = 2,
  parameter int ADDR_W = 20,
  parameter int DATA_W = 32
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // i/o mapped register port
  input wire logic io_sel,
  input wire logic io_we,
  input wire logic [SPACE_W+1:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // access requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [SPACE_W-1:0] req_space,
  input wire logic [ADDR_W-1:0] req_addr,
  output logic req_ack,
  output logic req_error,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // hand-off to synchronous controllers
  output logic sync_start,
  output logic [SPACE_W-1:0] sync_space,
  // external memory pins
  output logic [N_SPACE-1:0] mem_ce_b,
  output logic mem_oe_b,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_data_in,
  input wire logic async_ready_input
);

  // ==========================================================================
  // register file, one instance per space
  logic [15:0] sp_ctl1 [N_SPACE];   // timing register of each space
  logic [15:0] sp_rdata [N_SPACE];  // read data of each space
  logic [15:0] next_io_rdata;

  for (genvar i = 0; i < N_SPACE; i++)
  begin : g_space
    logic hit;  // register port addresses this space
    assign hit = (io_addr[SPACE_W+1:2] == SPACE_W'(i));
    amr_space_regs u_regs
    (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(io_sel && io_we && hit),
      .reg_idx(io_addr[1:0]),
      .wdata(io_wdata),
      .rdata(sp_rdata[i]),
      .ctl1(sp_ctl1[i])
    );
  end

  // read data is taken one edge after the read strobe
  always_comb
  begin
    next_io_rdata = io_rdata;
    if (io_sel && !io_we)
      next_io_rdata = sp_rdata[io_addr[SPACE_W+1:2]];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      io_rdata <= 16'h0000;
    else
      io_rdata <= next_io_rdata;
  end

  // ==========================================================================
  // pin synchronisers, only the second stage is used
  logic rdy_m;                 // first stage of ready
  logic rdy_s;                 // sampled ready
  logic [DATA_W-1:0] dat_m;    // first stage of read data
  logic [DATA_W-1:0] dat_s;    // sampled read data

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdy_m <= 1'b1;
      rdy_s <= 1'b1;
      dat_m <= '0;
      dat_s <= '0;
    end
    else
    begin
      rdy_m <= async_ready_input;
      rdy_s <= rdy_m;
      dat_m <= mem_data_in;
      dat_s <= dat_m;
    end
  end

  // ==========================================================================
  // cycle counts from field codes
  function automatic logic [5:0] setup_len(input logic [3:0] code,
                                           input logic first);
    if (code < SETUP_MIN_CODE)
      setup_len = first ? FIRST_SETUP : ONE_CYCLE;
    else
      setup_len = {2'b00, code};
  endfunction : setup_len

  function automatic logic [5:0] strobe_len(input logic [5:0] code);
    if (code < STROBE_MIN_CODE)
      strobe_len = ONE_CYCLE;
    else
      strobe_len = code;
  endfunction : strobe_len

  // ==========================================================================
  // access sequencer
  amr_state_type state;
  amr_state_type next_state;
  logic [5:0] cnt;                  // cycles left in the phase
  logic [5:0] next_cnt;
  logic [5:0] cur_strobe;           // latched strobe code
  logic [5:0] next_cur_strobe;
  logic [1:0] cur_hold;             // latched hold code
  logic [1:0] next_cur_hold;
  logic [SPACE_W-1:0] cur_space;    // space under access
  logic [SPACE_W-1:0] next_cur_space;
  logic first;                      // access opens a sequence
  logic next_first;
  logic ext;                        // strobe was stretched
  logic next_ext;
  logic [N_SPACE-1:0] next_ce_b;
  logic next_oe_b;
  logic [ADDR_W-1:0] next_addr;
  logic next_ack;
  logic next_error;
  logic next_rd_valid;
  logic [DATA_W-1:0] next_rd_data;
  logic next_sync_start;
  logic [SPACE_W-1:0] next_sync_space;
  logic take;                       // request accepted this edge
  logic done;                       // last cycle of an access
  logic [15:0] req_cfg;             // timing register of requested space
  logic [2:0] req_kind;
  logic [1:0] hold_eff;

  assign req_cfg = sp_ctl1[req_space];
  assign req_kind = req_cfg[TYPE_LSB +: TYPE_W];

  // next state and outputs of the sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_cur_strobe = cur_strobe;
    next_cur_hold = cur_hold;
    next_cur_space = cur_space;
    next_first = first;
    next_ext = ext;
    next_addr = mem_addr;
    next_ack = 1'b0;
    next_error = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_sync_start = 1'b0;
    next_sync_space = sync_space;
    take = 1'b0;
    done = 1'b0;
    // zero hold becomes one after a stretched strobe
    hold_eff = (cur_hold == 2'h0 && ext) ? 2'h1 : cur_hold;
    case (state)
      // wait for a request
      ST_IDLE:
        take = req_valid;
      // address and chip enable settle
      ST_SETUP:
        if (cnt == ONE_CYCLE)
        begin
          next_state = ST_STROBE;
          next_cnt = strobe_len(cur_strobe);
        end
        else
          next_cnt = cnt - 6'h01;
      // output enable active
      ST_STROBE:
        if (cnt != ONE_CYCLE)
          next_cnt = cnt - 6'h01;
        else if (!rdy_s)
          next_ext = 1'b1;
        else
        begin
          next_rd_valid = 1'b1;
          next_rd_data = dat_s;
          if (hold_eff == 2'h0)
            done = 1'b1;
          else
          begin
            next_state = ST_HOLD;
            next_cnt = {4'h0, hold_eff};
          end
        end
      // chip enable held after strobe
      ST_HOLD:
        if (cnt == ONE_CYCLE)
          done = 1'b1;
        else
          next_cnt = cnt - 6'h01;
      default:
        next_state = ST_IDLE;
    endcase
    // an access ends; a waiting request follows back to back
    if (done)
    begin
      next_state = ST_IDLE;
      take = req_valid;
    end
    // decode the accepted request by the kind of its space
    if (take)
    begin
      next_ack = 1'b1;
      next_state = ST_IDLE;
      if (req_kind == MT_SDRAM || req_kind == MT_BURST)
      begin
        next_sync_start = 1'b1;
        next_sync_space = req_space;
      end
      else if (req_kind > MT_BURST)
        next_error = 1'b1;
      else if (req_write)
        next_error = 1'b1;
      else
      begin
        next_state = ST_SETUP;
        next_first = (state == ST_IDLE);
        next_cnt = setup_len(req_cfg[SETUP_LSB +: SETUP_W],
                             state == ST_IDLE);
        next_cur_strobe = req_cfg[STROBE_LSB +: STROBE_W];
        next_cur_hold = req_cfg[HOLD_LSB +: HOLD_W];
        next_cur_space = req_space;
        next_ext = 1'b0;
        next_addr = req_addr;
      end
    end
    // pins follow the next state
    next_ce_b = '1;
    if (next_state != ST_IDLE)
      next_ce_b[next_cur_space] = 1'b0;
    next_oe_b = (next_state != ST_STROBE);
  end

  // register stage of the sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      cur_strobe <= 6'h00;
      cur_hold <= 2'h0;
      cur_space <= '0;
      first <= 1'b0;
      ext <= 1'b0;
      mem_ce_b <= '1;
      mem_oe_b <= 1'b1;
      mem_addr <= '0;
      req_ack <= 1'b0;
      req_error <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      sync_start <= 1'b0;
      sync_space <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      cur_strobe <= next_cur_strobe;
      cur_hold <= next_cur_hold;
      cur_space <= next_cur_space;
      first <= next_first;
      ext <= next_ext;
      mem_ce_b <= next_ce_b;
      mem_oe_b <= next_oe_b;
      mem_addr <= next_addr;
      req_ack <= next_ack;
      req_error <= next_error;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      sync_start <= next_sync_start;
      sync_space <= next_sync_space;
    end
  end

  // ==========================================================================
  // checks
  logic [7:0] phase_cnt;  // cycles spent in the current state
  logic [5:0] exp_setup;  // setup length due for this access

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_cnt <= 8'h01;
      exp_setup <= 6'h00;
    end
    else
    begin
      if (next_state != state || (take && next_state == ST_SETUP))
        phase_cnt <= 8'h01;
      else if (phase_cnt != 8'hff)
        phase_cnt <= phase_cnt + 8'h01;
      if (take)
        exp_setup <= setup_len(req_cfg[SETUP_LSB +: SETUP_W],
                               state == ST_IDLE);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_setup_length: assert property (
    state == ST_SETUP && next_state == ST_STROBE
    |-> phase_cnt == {2'b00, exp_setup})
    else $error("setup phase length wrong");
  a_first_setup_two: assert property (
    first && state == ST_SETUP && next_state == ST_STROBE
    |-> phase_cnt >= 8'h02)
    else $error("first setup shorter than two cycles");
  a_strobe_least: assert property (
    state == ST_STROBE && next_state != ST_STROBE
    |-> phase_cnt >= {2'b00, strobe_len(cur_strobe)})
    else $error("strobe shorter than programmed");
  a_hold_length: assert property (
    state == ST_HOLD && next_state != ST_HOLD
    |-> phase_cnt == {6'h00, hold_eff})
    else $error("hold phase length wrong");
  a_hold_after_stretch: assert property (
    state == ST_STROBE && cnt == ONE_CYCLE && rdy_s && ext
    |=> state == ST_HOLD ##1 state != ST_HOLD || cur_hold != 2'h0)
    else $error("stretched strobe missed its hold cycle");
  a_ready_stretch: assert property (
    state == ST_STROBE && cnt == ONE_CYCLE && !rdy_s
    |=> state == ST_STROBE && !mem_oe_b)
    else $error("strobe ended while ready low");
  a_pins_steady: assert property (
    state == ST_STROBE |-> $stable(mem_ce_b) && $stable(mem_addr))
    else $error("chip enable or address moved in strobe");
  a_data_capture: assert property (
    state == ST_STROBE && next_state != ST_STROBE
    |=> rd_valid && rd_data == $past(dat_s))
    else $error("read data not taken at strobe end");
  a_byte_no_write: assert property (
    take && req_write && req_kind == MT_ASYNC8
    |=> req_error && mem_ce_b == '1)
    else $error("write to 8-bit space not refused");
  a_sync_handoff: assert property (
    take && (req_kind == MT_SDRAM || req_kind == MT_BURST)
    |=> sync_start && state == ST_IDLE)
    else $error("synchronous kind not handed off");
  a_rsv_reads_zero: assert property (
    io_sel && !io_we && io_addr[1:0] == IDX_TIMING |=> !io_rdata[RSV_BIT])
    else $error("reserved bit read as one");

  c_stretched_read: cover property (
    state == ST_STROBE && !rdy_s ##1 rdy_s ##1 state == ST_HOLD);
  c_back_to_back: cover property (done && take && next_state == ST_SETUP);
  c_sync_select: cover property (sync_start);
  c_refused_write: cover property (req_error);

endmodule : amr_read_ctrl

// [hdl/amr_space_regs.sv]
// Purpose: the three control registers of one chip-enable space
// Assumes: write strobe already qualified by the space decode
// Notes: read data is combinational, the parent registers it

`timescale 1ns/1ps

module amr_space_regs
  import amr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic wr_en,
  input wire logic [1:0] reg_idx,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  // timing fields to the sequencer
  output logic [15:0] ctl1
);

  // ==========================================================================
  // storage
  logic [15:0] ctl2;         // write timing, stored only
  logic [15:0] ctl3;         // time-out, stored only
  logic [15:0] next_ctl1;
  logic [15:0] next_ctl2;
  logic [15:0] next_ctl3;

  // next values of the three registers
  always_comb
  begin
    next_ctl1 = ctl1;
    next_ctl2 = ctl2;
    next_ctl3 = ctl3;
    if (wr_en)
    begin
      case (reg_idx)
        IDX_TIMING: next_ctl1 = wdata & CTL1_MASK;
        IDX_CTL2: next_ctl2 = wdata;
        IDX_CTL3: next_ctl3 = wdata & CTL3_MASK;
        default: next_ctl1 = ctl1;                  // unmapped index
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl1 <= CTL1_RST;
      ctl2 <= CTL2_RST;
      ctl3 <= CTL3_RST;
    end
    else
    begin
      ctl1 <= next_ctl1;
      ctl2 <= next_ctl2;
      ctl3 <= next_ctl3;
    end
  end

  // read mux, unmapped index reads zero
  always_comb
  begin
    case (reg_idx)
      IDX_TIMING: rdata = ctl1;
      IDX_CTL2: rdata = ctl2;
      IDX_CTL3: rdata = ctl3;
      default: rdata = 16'h0000;
    endcase
  end

endmodule : amr_space_regs

// [tb/amr_mem_model.sv]
// Purpose: behavioural external asynchronous memory on the chip enables
// Assumes: ready line has a board pull-up while no space is selected
// Notes: stretch sets how many strobe cycles ready is held low

`timescale 1ns/1ps

module amr_mem_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // memory pins
  input wire logic [3:0] mem_ce_b,
  input wire logic mem_oe_b,
  input wire logic [19:0] mem_addr,
  output logic [31:0] mem_data_in,
  output logic async_ready_input,
  // bench control
  input wire logic [7:0] stretch
);
  logic [7:0] ocnt; // strobe cycles seen so far
  logic [31:0] junk; // floating bus, changes every cycle
  logic sel; // some space selected
  assign sel = ~&mem_ce_b;
  // count strobe cycles, restart on release
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ocnt <= 8'h00;
    else
      ocnt <= mem_oe_b ? 8'h00 : ocnt + 8'h01;
  end
  // undriven data flips every cycle
  always @(posedge clk)
  begin
    junk <= ~mem_data_in;
  end
  // selected memory shows its word early, else the bus floats
  assign mem_data_in = sel ? {12'hc3a, mem_addr} : junk;
  // low while not ready, pulled up when deselected
  assign async_ready_input = !(sel && ocnt < stretch);
endmodule : amr_mem_model

// [tb/amr_read_ctrl_tb.sv]
// Purpose: self-checking bench of the asynchronous read sequencer
// Assumes: one clock of 250 MHz, registers at {space, index}
// Notes: a monitor measures setup, strobe and hold of every read

`timescale 1ns/1ps

module amr_read_ctrl_tb;
  import amr_pkg::*;
  // ==========================================================================
  // signals
  logic clk, rst_b, io_sel, io_we, req_valid, req_write;
  logic [3:0] io_addr, mem_ce_b, ce_seen;
  logic [15:0] io_wdata, io_rdata, rv;
  logic [1:0] req_space, sync_space;
  logic [19:0] req_addr, cur_addr, mem_addr;
  logic req_ack, req_error, rd_valid, sync_start, mem_oe_b, ready, re, rs;
  logic [31:0] rd_data, mem_data_in;
  logic [7:0] stretch;
  int errors, n_checks, ph, cnt, i, s, t, h, sp, v;
  int q[$];
  amr_read_ctrl u_amr_read_ctrl (.clk(clk), .rst_b(rst_b), .io_sel(io_sel),
    .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .req_valid(req_valid), .req_write(req_write),
    .req_space(req_space), .req_addr(req_addr), .req_ack(req_ack),
    .req_error(req_error), .rd_valid(rd_valid), .rd_data(rd_data),
    .sync_start(sync_start), .sync_space(sync_space), .mem_ce_b(mem_ce_b),
    .mem_oe_b(mem_oe_b), .mem_addr(mem_addr), .mem_data_in(mem_data_in),
    .async_ready_input(ready));
  amr_mem_model u_amr_mem_model (.clk(clk), .rst_b(rst_b),
    .mem_ce_b(mem_ce_b), .mem_oe_b(mem_oe_b), .mem_addr(mem_addr),
    .mem_data_in(mem_data_in), .async_ready_input(ready),
    .stretch(stretch));
  // ==========================================================================
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic int e_su(int c, bit f);
    return c > 2 ? c : (f ? 2 : 1);
  endfunction : e_su
  function automatic int e_st(int c);
    return c < 2 ? 1 : c;
  endfunction : e_st
  // one register cycle, read data taken the cycle after
  task automatic io(logic we, logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    io_sel <= 1'b1;
    io_we <= we;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_sel <= 1'b0;
    @(posedge clk);
    rv = io_rdata;
  endtask : io
  task automatic prog(int p, int k, int su, int sb, int hd);
    io(1'b1, {p[1:0], IDX_TIMING}, {1'b0, k[2:0], su[3:0], sb[5:0], hd[1:0]});
  endtask : prog
  // request; pulse when idle, or hold until ack when busy
  task automatic req(int p, logic wr, bit hold_on);
    int k;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_space <= p[1:0];
    if (!hold_on)
    begin
      @(posedge clk);
      req_valid <= 1'b0;
    end
    for (k = 0; k < 300 && req_ack !== 1'b1; k++)
      @(posedge clk);
    req_valid <= 1'b0;
    re = req_error;
    rs = sync_start;
  endtask : req
  task automatic pop3(int su, int sb, int hd);
    int k;
    for (k = 0; k < 500 && q.size() < 3; k++)
      @(posedge clk);
    chk("n_phases", 3, q.size());
    if (q.size() >= 3)
    begin
      chk("setup", su, q.pop_front());
      chk("strobe", sb, q.pop_front());
      chk("hold", hd, q.pop_front());
    end
  endtask : pop3
  // ==========================================================================
  // monitor: phase lengths of async reads, data at strobe end
  always @(posedge clk)
  begin
    case (ph)
      1: if (!mem_oe_b) begin q.push_back(cnt); ph = 2; cnt = 1; end
         else cnt++;
      2: if (mem_oe_b)
         begin
           q.push_back(cnt);
           chk("rd_valid", 1, rd_valid);
           chk("rd_data", {12'hc3a, cur_addr}, rd_data);
           chk("mem_addr", cur_addr, mem_addr);
           if (&mem_ce_b || req_ack) begin q.push_back(0); ph = 0; end
           else begin ph = 3; cnt = 1; end
         end
         else cnt++;
      3: if (&mem_ce_b || req_ack) begin q.push_back(cnt); ph = 0; end
         else cnt++;
      default: ph = 0;
    endcase
    if (req_ack && !req_error && !sync_start)
    begin
      ph = 1;
      cnt = 1;
      ce_seen = mem_ce_b;
    end
  end
  // ==========================================================================
  // clock, watchdog and verdict
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    results();
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // ==========================================================================
  // main sequence
  initial
  begin
    {rst_b, io_sel, io_we, req_valid, req_write} = 5'h00;
    {io_addr, io_wdata, req_space, req_addr, stretch} = '0;
    cur_addr = '0;
    ph = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    void'($urandom(86072));
    // reset values of every space and index
    for (i = 0; i < 16; i++)
    begin
      io(1'b0, i[3:0], 16'h0000);
      chk("reg_rst", i[1:0] == 2'h0 ? CTL1_RST : 16'h0000, rv);
    end
    // reserved bits and unmapped index
    io(1'b1, 4'h8, 16'hffff);
    io(1'b0, 4'h8, 16'h0000);
    chk("top_bit", 16'h7fff, rv);
    io(1'b1, 4'hb, 16'hffff);
    io(1'b0, 4'hb, 16'h0000);
    chk("unmapped", 16'h0000, rv);
    io(1'b1, 4'h5, 16'hffff);
    io(1'b0, 4'h5, 16'h0000);
    chk("ctl2", 16'hffff, rv);
    io(1'b1, 4'h6, 16'hffff);
    io(1'b0, 4'h6, 16'h0000);
    chk("ctl3_top", 16'h00ff, rv);
    // corner then random async reads from idle
    for (i = 0; i < 24; i++)
    begin
      sp = $urandom % 4;
      s = i < 16 ? i : $urandom % 16;
      t = i < 2 ? i : (i == 3 ? 63 : $urandom % 12);
      h = i % 4;
      prog(sp, i % 3, s, t, h);
      cur_addr = 20'($urandom);
      req_addr <= cur_addr;
      req(sp, 1'b0, 1'b0);
      pop3(e_su(s, 1), e_st(t), h);
      chk("ce", 4'hf ^ (4'h1 << sp), ce_seen);
    end
    // ready stretches the strobe, zero hold becomes one
    stretch <= 8'h06;
    prog(1, 2, 3, 2, 0);
    req(1, 1'b0, 1'b0);
    for (i = 0; i < 500 && q.size() < 3; i++)
      @(posedge clk);
    v = q.size() >= 3 ? q[1] : 0;
    chk("stretch", 1, v >= 6 && v <= 9);
    chk("stretch_hold", 1, q.size() >= 3 ? q[2] : 0);
    q.delete();
    stretch <= 8'h00;
    // back to back: first setup two, next setup one
    prog(0, 1, 0, 1, 1);
    req(0, 1'b0, 1'b0);
    req(0, 1'b0, 1'b1);
    pop3(2, 1, 1);
    pop3(1, 1, 1);
    // synchronous kinds hand off, reserved kinds and writes refused
    for (i = 3; i < 8; i++)
    begin
      prog(2, i, $urandom % 16, $urandom % 64, $urandom % 4);
      req(2, 1'b0, 1'b0);
      chk("sync_start", i < 5, rs);
      chk("kind_err", i > 4, re);
      chk("no_pins", 4'hf, mem_ce_b);
      if (i < 5)
        chk("sync_space", 2, sync_space);
    end
    prog(3, 0, 3, 2, 1);
    req(3, 1'b1, 1'b0);
    chk("wr_err", 1, re);
    chk("wr_pins", 4'hf, mem_ce_b);
    repeat (4) @(posedge clk);
    chk("leftover", 0, q.size());
    results();
  end
endmodule : amr_read_ctrl_tb
